// file: hdl/ddr_sio_sram_port.sv
// Two-word burst separate-IO SRAM port with its read data FIFO.
`timescale 1ns/1ps
`default_nettype none
`include "sram_port_regs.svh"

module sram_port_fifo #(
  parameter int WIDTH = `FIFO_W,
  parameter int DEPTH = `FIFO_DEPTH
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [PW:0] FULL_COUNT = (PW+1)'(DEPTH);
  localparam logic [PW-1:0] LAST_SLOT = PW'(DEPTH - 1);

  logic [WIDTH-1:0] slot [0:DEPTH-1];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [PW:0] count;
  logic push;
  logic pop;

  assign in_ready = (count != FULL_COUNT);
  assign out_valid = (count != '0);
  assign out_data = slot[rd_ptr];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  function automatic logic [PW-1:0] step(input logic [PW-1:0] ptr);
    step = (ptr == LAST_SLOT) ? '0 : ptr + 1'b1;
  endfunction : step

  always_ff @(posedge clk_sys)
  begin
    if (push)
      slot[wr_ptr] <= in_data;
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end
    else
    begin
      if (push)
        wr_ptr <= step(wr_ptr);
      if (pop)
        rd_ptr <= step(rd_ptr);
      if (push && !pop)
      begin
        count <= count + 1'b1;
      end
      else if (pop && !push)
      begin
        count <= count - 1'b1;
      end
    end
  end

endmodule : sram_port_fifo

// What this block does
// - Write data is captured on rising edges of both input strobe phases during writes.
// - Every access moves exactly two words, one per half clock period.
// - In 8-bit mode nibble select 0 gates bits 3..0, select 1 bits 7..4.
// - A deasserted nibble select leaves that stored nibble unchanged.
// - Each write select is sampled with the data word it qualifies.
// - Byte selects sampled on both phases; 9-bit mode select 0 covers nine bits.
// - The address is sampled only on the positive input strobe rising edge.
// - One address bus serves reads and writes in turn.
// - Storage is two half-depth arrays; address width 21, 20 or 19 by mode.
// - Address inputs are ignored when the port is not selected this cycle.
// - Read words go out on both output clock phases, or input phases in single mode.
// - When no read data is due, the read outputs are released.
// - Every access begins on the positive input strobe rising edge.
// - A free-running echo clock follows the output clock, or the input clock in single mode.
module ddr_sio_sram_port
  import sram_port_pkg::*;
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire lane_mode_e lane_mode,
  input wire logic single_clock_mode,
  input wire logic input_timing_strobe,
  input wire logic input_timing_strobe_n,
  input wire logic output_timing_pair,
  input wire logic output_timing_pair_n,
  input wire logic load_strobe_n,
  input wire logic read_write_select,
  input wire logic [`ADDR_W-1:0] address,
  input wire logic [`DATA_W-1:0] write_input,
  input wire logic [`BYTE_SEL_W-1:0] byte_write_select_n,
  input wire logic [`NIB_SEL_W-1:0] nibble_write_select_n,
  output logic [`DATA_W-1:0] read_output,
  output logic read_output_oe,
  output logic echo_clock,
  output logic echo_clock_n,
  output logic read_overrun
);

  localparam int PIN_W = 5 + `ADDR_W + `DATA_W + `BYTE_SEL_W + `NIB_SEL_W;
  localparam int MEM_DEPTH = 1 << `MEM_AW;

  // Every pin except lane_mode passes two flip-flops; the second stage feeds the logic.
  logic [PIN_W-1:0] pin_s1;
  logic [PIN_W-1:0] pin_s2;
  logic [3:0] clk_s3;
  logic [3:0] clk_s2;
  logic ld_n_s;
  logic rw_s;
  logic single_s;
  logic [`ADDR_W-1:0] addr_s;
  logic [`DATA_W-1:0] din_s;
  logic [`BYTE_SEL_W-1:0] bws_n_s;
  logic [`NIB_SEL_W-1:0] nws_n_s;
  logic [1:0] cmd_s1;
  logic [1:0] cmd_s2;

  assign clk_s2 = pin_s2[PIN_W-1:PIN_W-4];
  assign single_s = pin_s2[PIN_W-5];
  assign {addr_s, din_s, bws_n_s, nws_n_s} = pin_s2[PIN_W-6:0];
  assign ld_n_s = cmd_s2[1];
  assign rw_s = cmd_s2[0];

  // Pin vector layout, high to low: clocks, single mode, address, data, selects.
  // Load and select have their own pair of stages, which resets to an idle bus.
  logic [PIN_W-1:0] pin_raw;
  assign pin_raw = {input_timing_strobe, input_timing_strobe_n, output_timing_pair,
                    output_timing_pair_n, single_clock_mode, address, write_input,
                    byte_write_select_n, nibble_write_select_n};

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      pin_s1 <= '0;
      pin_s2 <= '0;
      clk_s3 <= '0;
      cmd_s1 <= 2'h3;
      cmd_s2 <= 2'h3;
    end
    else
    begin
      pin_s1 <= pin_raw;
      pin_s2 <= pin_s1;
      clk_s3 <= clk_s2;
      cmd_s1 <= {load_strobe_n, read_write_select};
      cmd_s2 <= cmd_s1;
    end
  end

  logic k_rise;
  logic kn_rise;
  logic c_rise;
  logic cn_rise;
  logic out_edge;

  assign k_rise = clk_s2[3] & ~clk_s3[3];
  assign kn_rise = clk_s2[2] & ~clk_s3[2];
  assign c_rise = clk_s2[1] & ~clk_s3[1];
  assign cn_rise = clk_s2[0] & ~clk_s3[0];
  assign out_edge = single_s ? (k_rise | kn_rise) : (c_rise | cn_rise);

  // Bits of a word that exist in the selected width.
  function automatic word_t width_mask(input lane_mode_e mode);
    unique case (mode)
      LANE_X36: width_mask = {`DATA_W{1'b1}};
      LANE_X18: width_mask = word_t'({`WORD_W_X18{1'b1}});
      LANE_X9: width_mask = word_t'({`WORD_W_X9{1'b1}});
      LANE_X8: width_mask = word_t'({`WORD_W_X8{1'b1}});
    endcase
  endfunction : width_mask

  // Active-high write enable per data bit from the selects of one half of the burst.
  function automatic word_t write_mask(input lane_mode_e mode,
                                       input logic [`BYTE_SEL_W-1:0] bws_n,
                                       input logic [`NIB_SEL_W-1:0] nws_n);
    write_mask = '0;
    unique case (mode)
      LANE_X8:
      begin
        write_mask[`NIB_W-1:0] = {`NIB_W{~nws_n[0]}};
        write_mask[2*`NIB_W-1:`NIB_W] = {`NIB_W{~nws_n[1]}};
      end
      LANE_X9:
        write_mask[`LANE_W-1:0] = {`LANE_W{~bws_n[0]}};
      default:
      begin
        for (int i = 0; i < `BYTE_SEL_W; i++)
        begin
          write_mask[i*`LANE_W +: `LANE_W] = {`LANE_W{~bws_n[i]}};
        end
      end
    endcase
    write_mask = write_mask & width_mask(mode);
  endfunction : write_mask

  function automatic word_t merge(input word_t old_word, input word_t new_word,
                                  input word_t mask);
    merge = (old_word & ~mask) | (new_word & mask);
  endfunction : merge

  // Address bits that the selected organisation decodes.
  function automatic logic [`ADDR_W-1:0] used_address(input lane_mode_e mode,
                                                      input logic [`ADDR_W-1:0] addr);
    unique case (mode)
      LANE_X36: used_address = addr & `ADDR_W'({`ADDR_W_X36{1'b1}});
      LANE_X18: used_address = addr & `ADDR_W'({`ADDR_W_X18{1'b1}});
      default: used_address = addr & `ADDR_W'({`ADDR_W_X9{1'b1}});
    endcase
  endfunction : used_address

  // Two half-depth arrays: the first word of a burst lives in one, the second in the other.
  word_t mem_first [0:MEM_DEPTH-1];
  word_t mem_second [0:MEM_DEPTH-1];

  logic cmd_take;
  logic write_cmd;
  logic read_cmd;
  logic [`ADDR_W-1:0] cmd_addr;
  logic [`MEM_AW-1:0] cmd_index;
  logic [`MEM_AW-1:0] wr_index;
  logic wr_second_due;
  logic rd_second_due;
  word_t rd_second_word;
  word_t cur_mask;
  logic fifo_in_valid;
  logic fifo_in_ready;
  word_t fifo_in_data;
  logic fifo_out_valid;
  word_t fifo_out_data;

  // A bus cycle is defined only on the positive strobe edge with load low; otherwise the
  // address pins are not looked at.
  assign cmd_take = k_rise & ~ld_n_s;
  assign write_cmd = cmd_take & ~rw_s;
  assign read_cmd = cmd_take & rw_s & ~rd_second_due & fifo_in_ready;
  assign cmd_addr = used_address(lane_mode, addr_s);
  assign cmd_index = cmd_addr[`MEM_AW-1:0];
  assign cur_mask = write_mask(lane_mode, bws_n_s, nws_n_s);

  // First write word on the command edge, second on the following negative-phase edge.
  always_ff @(posedge clk_sys)
  begin
    if (write_cmd)
    begin
      mem_first[cmd_index] <= merge(mem_first[cmd_index], din_s, cur_mask);
    end
    if (kn_rise && wr_second_due)
    begin
      mem_second[wr_index] <= merge(mem_second[wr_index], din_s, cur_mask);
    end
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      wr_index <= '0;
      wr_second_due <= 1'b0;
    end
    else if (write_cmd)
    begin
      wr_index <= cmd_index;
      wr_second_due <= 1'b1;
    end
    else if (kn_rise)
    begin
      wr_second_due <= 1'b0;
    end
  end

  // A read pushes both burst words into the FIFO; the second waits for room if needed.
  assign fifo_in_valid = read_cmd | rd_second_due;
  assign fifo_in_data = (read_cmd ? mem_first[cmd_index] : rd_second_word) &
                        width_mask(lane_mode);

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      rd_second_due <= 1'b0;
      rd_second_word <= '0;
    end
    else if (read_cmd)
    begin
      rd_second_due <= 1'b1;
      rd_second_word <= mem_second[cmd_index];
    end
    else if (fifo_in_ready)
    begin
      rd_second_due <= 1'b0;
    end
  end

  // A read that cannot be queued is dropped and flagged for one cycle.
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      read_overrun <= 1'b0;
    end
    else
    begin
      read_overrun <= cmd_take & rw_s & (rd_second_due | ~fifo_in_ready);
    end
  end

  sram_port_fifo #(
    .WIDTH(`FIFO_W),
    .DEPTH(`FIFO_DEPTH)
  ) u_read_fifo (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in_data),
    .out_valid(fifo_out_valid),
    .out_ready(out_edge),
    .out_data(fifo_out_data)
  );

  // Each output edge presents the next word, or releases the pins when none is due.
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      read_output <= `READ_OUTPUT_RESET;
      read_output_oe <= 1'b0;
    end
    else if (out_edge)
    begin
      read_output <= fifo_out_valid ? fifo_out_data : `READ_OUTPUT_RESET;
      read_output_oe <= fifo_out_valid;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      echo_clock <= 1'b0;
      echo_clock_n <= 1'b0;
    end
    else
    begin
      echo_clock <= single_s ? clk_s2[3] : clk_s2[1];
      echo_clock_n <= single_s ? clk_s2[2] : clk_s2[0];
    end
  end

endmodule : ddr_sio_sram_port
`default_nettype wire

// file: hdl/sram_port_pkg.sv
// Types shared by the burst SRAM port.
`default_nettype none
`include "sram_port_regs.svh"

package sram_port_pkg;

  typedef enum logic [1:0] {
    LANE_X36 = 2'h0,
    LANE_X18 = 2'h1,
    LANE_X9 = 2'h2,
    LANE_X8 = 2'h3
  } lane_mode_e;

  typedef logic [`DATA_W-1:0] word_t;

endpackage : sram_port_pkg
`default_nettype wire

// file: hdl/sram_port_regs.svh
// Constants for the burst SRAM port: widths, lane layout, storage depth and reset values.
`ifndef SRAM_PORT_REGS_SVH
`define SRAM_PORT_REGS_SVH

`define DATA_W 36
`define BYTE_SEL_W 4
`define NIB_SEL_W 2
`define ADDR_W 21
`define ADDR_W_X36 19
`define ADDR_W_X18 20
`define ADDR_W_X9 21
`define LANE_W 9
`define NIB_W 4
`define WORD_W_X36 36
`define WORD_W_X18 18
`define WORD_W_X9 9
`define WORD_W_X8 8
`define MEM_AW 6
`define FIFO_W 36
`define FIFO_DEPTH 4
`define READ_OUTPUT_RESET 36'h0_0000_0000

`endif

// file: tb/ddr_sio_sram_port_bench.sv
// Bench for the burst SRAM port: reference memory, random bursts and a read overrun.
`timescale 1ns/1ps
`default_nettype none
`include "sram_port_regs.svh"
module ddr_sio_sram_port_bench
  import sram_port_pkg::*;
;
  logic clk_sys, resetn, single_clock_mode, kp, kn, cp, cn, lsn, rws, oe, eck, eck_n, ovr;
  lane_mode_e lane_mode;
  logic [`ADDR_W-1:0] adr, a;
  logic [`DATA_W-1:0] wd, q, d0, d1, s;
  logic [`BYTE_SEL_W-1:0] bsel;
  logic [`NIB_SEL_W-1:0] nsel;
  logic [35:0] m0[int], m1[int];
  logic [31:0] seed;
  int n_errors, compares, n_over;
  ddr_sio_sram_port ddr_sio_sram_port_inst (.clk_sys(clk_sys), .resetn(resetn),
    .lane_mode(lane_mode), .single_clock_mode(single_clock_mode), .input_timing_strobe(kp),
    .input_timing_strobe_n(kn), .output_timing_pair(cp), .output_timing_pair_n(cn),
    .load_strobe_n(lsn), .read_write_select(rws), .address(adr), .write_input(wd),
    .byte_write_select_n(bsel), .nibble_write_select_n(nsel), .read_output(q),
    .read_output_oe(oe), .echo_clock(eck), .echo_clock_n(eck_n), .read_overrun(ovr));
  sram_ctrl_model sram_ctrl_model_inst (.clk_sys(clk_sys), .input_timing_strobe(kp),
    .input_timing_strobe_n(kn), .output_timing_pair(cp), .output_timing_pair_n(cn),
    .load_strobe_n(lsn), .read_write_select(rws), .address(adr), .write_input(wd),
    .byte_write_select_n(bsel), .nibble_write_select_n(nsel));
  initial
  begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys)
    if (ovr === 1'b1)
      n_over++;
  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr_next
  function automatic logic [35:0] wmask(input int m, input logic [3:0] b, input logic [1:0] n);
    logic [35:0] r;
    r = {{9{~b[3]}}, {9{~b[2]}}, {9{~b[1]}}, {9{~b[0]}}};
    if (m == 1)
      r[35:18] = '0;
    if (m == 2)
      r[35:9] = '0;
    if (m == 3)
      r = {28'h000_0000, {4{~n[1]}}, {4{~n[0]}}};
    return r;
  endfunction : wmask
  task rnd(output logic [35:0] v);
    seed = lfsr_next(seed);
    v[35:32] = seed[3:0];
    seed = lfsr_next(seed);
    v[31:0] = seed;
  endtask : rnd
  task chk(input string what, input logic [35:0] exp, input logic [35:0] got);
    compares++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task end_of_test();
    $display("TB: %0d compares, %0d mismatches", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : end_of_test
  task wr(input logic [3:0] b0, b1, input logic [1:0] n0, n1);
    logic [35:0] k0, k1;
    k0 = wmask(lane_mode, b0, n0);
    k1 = wmask(lane_mode, b1, n1);
    rnd(d0);
    rnd(d1);
    sram_ctrl_model_inst.push({1'b0, a, d0, d1, b0, b1, n0, n1});
    m0[a[5:0]] = (m0[a[5:0]] & ~k0) | (d0 & k0);
    m1[a[5:0]] = (m1[a[5:0]] & ~k1) | (d1 & k1);
  endtask : wr
  task collect(input int nw);
    int i;
    @(negedge clk_sys);
    for (i = 0; i < 64 && oe !== 1'b1; i++)
      @(negedge clk_sys);
    if (i == 64)
    begin
      n_errors++;
      $display("[ERR] read_output_oe expected 1 seen %b", oe);
      end_of_test();
    end
    for (i = 0; i < nw; i++)
    begin
      s = (i % 2) ? m1[a[5:0]] : m0[a[5:0]];
      chk("read_output", s & wmask(lane_mode, 4'h0, 2'h0), q);
      repeat (4) @(negedge clk_sys);
    end
    chk("released", 36'h0_0000_0000, {35'h0, oe} | q);
  endtask : collect
  initial
  begin
    seed = 32'h5234_02cf;
    {n_errors, compares, n_over} = '0;
    resetn = 1'b0;
    lane_mode = LANE_X36;
    single_clock_mode = 1'b0;
    repeat (20) @(negedge clk_sys);
    resetn = 1'b1;
    for (int m = 0; m < 5; m++)
    begin
      lane_mode = lane_mode_e'(m % 4);
      single_clock_mode = (m == 2);
      repeat (8) @(negedge clk_sys);
      rnd(s);
      a = s[20:0];
      wr(4'h0, 4'h0, 2'h0, 2'h0);
      rnd(s);
      if (m < 4)
      begin
        wr(s[3:0], s[7:4], s[9:8], s[11:10]);
        sram_ctrl_model_inst.push({1'b1, a, 84'h0});
        collect(2);
      end
      else
      begin
        @(posedge clk_sys);
        sram_ctrl_model_inst.out_run = 1'b0;
        n_over = 0;
        for (int j = 0; j < 3; j++)
          sram_ctrl_model_inst.push({1'b1, a, 84'h0});
        repeat (48) @(negedge clk_sys);
        chk("read_overrun", 36'h0_0000_0001, 36'(n_over));
        @(posedge clk_sys);
        sram_ctrl_model_inst.out_run = 1'b1;
        collect(4);
      end
      $display("Test %0d done", m);
    end
    end_of_test();
  end
endmodule : ddr_sio_sram_port_bench
bind ddr_sio_sram_port ddr_sio_sram_port_checker ddr_sio_sram_port_checker_inst (
  .clk_sys(clk_sys), .resetn(resetn), .single_clock_mode(single_clock_mode),
  .input_timing_strobe(input_timing_strobe), .output_timing_pair(output_timing_pair),
  .input_timing_strobe_n(input_timing_strobe_n), .output_timing_pair_n(output_timing_pair_n),
  .load_strobe_n(load_strobe_n), .read_write_select(read_write_select),
  .read_output(read_output), .read_output_oe(read_output_oe), .echo_clock(echo_clock),
  .echo_clock_n(echo_clock_n),
  .read_overrun(read_overrun));
`default_nettype wire

// file: tb/ddr_sio_sram_port_checker.sv
// Concurrent checks on the pins of the burst SRAM port.
`timescale 1ns/1ps
`default_nettype none
`include "sram_port_regs.svh"
module ddr_sio_sram_port_checker (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic single_clock_mode,
  input wire logic input_timing_strobe,
  input wire logic input_timing_strobe_n,
  input wire logic output_timing_pair,
  input wire logic output_timing_pair_n,
  input wire logic load_strobe_n,
  input wire logic read_write_select,
  input wire logic [`DATA_W-1:0] read_output,
  input wire logic read_output_oe,
  input wire logic echo_clock,
  input wire logic echo_clock_n,
  input wire logic read_overrun
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);
  sequence read_cmd;
    $rose(input_timing_strobe) && !load_strobe_n && read_write_select;
  endsequence
  sequence word_hold;
    $stable(read_output)[*2];
  endsequence
  reset_quiet_a:
    assert property ($rose(resetn) |-> !read_output_oe && !read_overrun && !echo_clock)
    else $error("outputs not quiet after reset");
  released_zero_a:
    assert property (!read_output_oe |-> read_output == `READ_OUTPUT_RESET)
    else $error("read data seen while released");
  read_answer_a:
    assert property (read_cmd ##0 single_clock_mode |-> ##[3:24] read_output_oe)
    else $error("read data not driven in time");
  word_stands_a:
    assert property ($changed(read_output) |=> word_hold)
    else $error("read word did not stand");
  echo_out_a:
    assert property ((!single_clock_mode)[*6] |-> echo_clock == $past(output_timing_pair, 3))
    else $error("echo clock does not follow output clock");
  echo_single_a:
    assert property (single_clock_mode[*6] |-> echo_clock == $past(input_timing_strobe, 3))
    else $error("echo clock does not follow input clock");
  echo_bar_out_a:
    assert property ((!single_clock_mode)[*6] |-> echo_clock_n == $past(output_timing_pair_n, 3))
    else $error("inverted echo clock does not follow inverted output clock");
  echo_bar_single_a:
    assert property (single_clock_mode[*6] |-> echo_clock_n == $past(input_timing_strobe_n, 3))
    else $error("inverted echo clock does not follow inverted input clock");
  overrun_pulse_a:
    assert property (read_overrun |=> !read_overrun)
    else $error("overrun longer than one cycle");
  overrun_cause_a:
    assert property (read_overrun |-> $past(read_write_select, 3) && !$past(load_strobe_n, 3))
    else $error("overrun without a read command");
endmodule : ddr_sio_sram_port_checker
`default_nettype wire

// file: tb/sram_ctrl_model.sv
// Controller model: strobe pairs, queued commands and two-word write bursts.
`timescale 1ns/1ps
`default_nettype none
`include "sram_port_regs.svh"
module sram_ctrl_model (
  input wire logic clk_sys,
  output logic input_timing_strobe,
  output logic input_timing_strobe_n,
  output logic output_timing_pair,
  output logic output_timing_pair_n,
  output logic load_strobe_n,
  output logic read_write_select,
  output logic [`ADDR_W-1:0] address,
  output logic [`DATA_W-1:0] write_input,
  output logic [`BYTE_SEL_W-1:0] byte_write_select_n,
  output logic [`NIB_SEL_W-1:0] nibble_write_select_n
);
  logic out_run = 1'b1;
  // The output pair starts or stops only at a period boundary, so no level is cut short.
  logic run_now = 1'b1;
  logic [2:0] ph = 3'h0;
  logic [105:0] q[$];
  logic [105:0] cur = '0;
  initial
  begin
    {input_timing_strobe, input_timing_strobe_n, output_timing_pair, output_timing_pair_n} = '0;
    {load_strobe_n, read_write_select, address, write_input} = {2'h2, 57'h0};
    {byte_write_select_n, nibble_write_select_n} = '0;
  end
  task push(input logic [105:0] cmd);
    @(posedge clk_sys);
    q.push_back(cmd);
  endtask : push
  // While idle, read_write_select, address and write_input toggle so a stale value can never pass for a real one.
  always @(negedge clk_sys)
  begin
    if (ph == 3'h0)
    begin
      run_now = out_run;
      load_strobe_n = (q.size() == 0);
      if (!load_strobe_n)
      begin
        cur = q.pop_front();
        read_write_select = cur[105];
        address = cur[104:84];
        write_input = cur[83:48];
        byte_write_select_n = cur[11:8];
        nibble_write_select_n = cur[3:2];
      end
      else
      begin
        read_write_select = ~read_write_select;
        address = ~address;
        write_input = ~write_input;
      end
    end
    if (ph == 3'h4)
    begin
      write_input = load_strobe_n ? ~write_input : cur[47:12];
      byte_write_select_n = cur[7:4];
      nibble_write_select_n = cur[1:0];
    end
    input_timing_strobe = (ph < 3'h4);
    input_timing_strobe_n = (ph >= 3'h4);
    output_timing_pair = run_now & (ph < 3'h4);
    output_timing_pair_n = run_now & (ph >= 3'h4);
    ph = ph + 3'h1;
  end
endmodule : sram_ctrl_model
`default_nettype wire
